// *** pkg/clp_defs.svh ***
/*
 Constants of the character display instruction port: opcode bit positions,
 field positions, address limits, reset values and timing figures.
 Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef CLP_DEFS_SVH
`define CLP_DEFS_SVH
`define CLP_CLK_NS        10
`define CLP_EXEC_NS       18500
`define CLP_CLEAR_NS      760000
`define CLP_BLINK_NS      185000000
`define CLP_EXEC_CYC      ((`CLP_EXEC_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)
`define CLP_CLEAR_CYC     ((`CLP_CLEAR_NS + `CLP_CLK_NS - 1) / `CLP_CLK_NS)
`define CLP_BLINK_CYC     (`CLP_BLINK_NS / `CLP_CLK_NS)
`define CLP_BUSY_W        20
`define CLP_BLINK_W       25
`define CLP_OP_FUN        5
`define CLP_FUN_DL        4
`define CLP_FUN_N         3
`define CLP_FUN_F         2
`define CLP_SHF_SC        3
`define CLP_SHF_RL        2
`define CLP_DSP_D         2
`define CLP_DSP_C         1
`define CLP_DSP_B         0
`define CLP_ENT_ID        1
`define CLP_ENT_S         0
`define CLP_SPI_CSN       5
`define CLP_SPI_SCK       6
`define CLP_SPI_SDI       7
`define CLP_SPACE_CODE    8'h20
`define CLP_DD_ONE_LAST   7'h4f
`define CLP_DD_L1_LAST    7'h27
`define CLP_DD_L2_FIRST   7'h40
`define CLP_DD_L2_LAST    7'h67
`define CLP_DD_DEPTH      128
`define CLP_CG_DEPTH      64
`define CLP_RST_AC        7'h00
`define CLP_RST_CG_DATA   8'h00
`endif

// *** pkg/clp_pkg.sv ***
/*
 Types of the character display instruction port: interface and duty codes,
 the synchronised pin bundle and the byte command bundle.
 Assumes nothing of its surroundings.
*/
package clp_pkg;
   typedef enum logic [1:0] {
      CLP_IF_PAR = 2'b00,
      CLP_IF_TWI = 2'b01,
      CLP_IF_SPI = 2'b10
   } clp_iface_type;
   typedef enum logic [1:0] {
      CLP_DUTY_8  = 2'b00,
      CLP_DUTY_11 = 2'b01,
      CLP_DUTY_16 = 2'b10
   } clp_duty_type;
   typedef struct packed {
      logic       strap_hi;
      logic       strap_lo;
      logic       e;
      logic       rs;
      logic       rw;
      logic [7:0] db;
   } clp_pins_type;
   typedef struct packed {
      logic       valid;
      logic       rs;
      logic [7:0] data;
   } clp_cmd_type;
endpackage : clp_pkg

// *** design/clp_sync.sv ***
/*
 Two-stage synchroniser for a bundle of pin levels.
 Assumes the inputs are asynchronous, static long against the clock period.
*/
`timescale 1ns/10ps
`default_nettype none
module clp_sync #(
   parameter int W = 13
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         nrst,
   // Levels.
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end
   assign q = q_ff;
endmodule : clp_sync
`default_nettype wire

// *** design/clp_spi_rx.sv ***
/*
 Four-line serial receiver: assembles bytes MSB first on rising serial clock
 while select is low. Assumes all inputs are already synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module clp_spi_rx
   import clp_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        nrst,
   // Serial lines.
   input  wire logic        en,
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        sdi,
   input  wire logic        rs,
   // Assembled byte.
   output var  clp_cmd_type cmd
);
   logic        sck_d_ff;
   logic [2:0]  cnt_ff;
   logic [6:0]  sh_ff;
   clp_cmd_type cmd_ff;
   wire         rise = sck & ~sck_d_ff & ~cs_n & en;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sck_d_ff <= 1'b1;
         cnt_ff   <= 3'h0;
         sh_ff    <= 7'h00;
         cmd_ff   <= '0;
      end else begin
         sck_d_ff     <= sck;
         cmd_ff.valid <= rise & (cnt_ff == 3'h7);
         if (cs_n) begin
            cnt_ff <= 3'h0;
         end else if (rise) begin
            cnt_ff <= cnt_ff + 3'h1;
            sh_ff  <= {sh_ff[5:0], sdi};
            if (cnt_ff == 3'h7) begin
               cmd_ff.data <= {sh_ff, sdi};
               cmd_ff.rs   <= rs;
            end
         end
      end
   end
   assign cmd = cmd_ff;
endmodule : clp_spi_rx
`default_nettype wire

// *** design/clp_core.sv ***
/*
 Instruction decoder and host port of a character display controller:
 parallel 8/4-bit bus or four-line serial, display RAM and character RAM,
 address counter, busy flag, display shift and blink timing.
 Assumes all pins are asynchronous to CLK_SYS and the straps are static.
*/
// Summary of operation
// - Display bit one shows the display; zero blanks it, RAM kept.
// - Cursor bit shows the cursor; clearing it keeps the entry direction.
// - Blink bit toggles cursor cell with full block every 185 ms.
// - Shift instruction moves cursor with counter, or the whole display.
// - Display shift leaves the address counter and RAM untouched.
// - In two-line mode cursor past position 40 goes to line two.
// - Width bit one selects 8-bit bus, zero the 4-bit bus.
// - Line and font bits pick one line 5x8, 5x11, or two lines.
// - Character RAM address set loads the counter and selects that RAM.
// - Display RAM address set loads the counter and selects display RAM.
// - Display addresses wrap within the valid ranges for the line mode.
// - Status read returns busy flag on bit 7 and the counter below.
// - Data write stores a byte and steps the counter per entry mode.
// - Data read returns the preloaded register, then steps the counter.
// - 4-bit transfers send high nibble first; busy after the second.
// - Two straps select parallel or four-line serial; the two-wire code enables neither port.
// - Parallel bus uses strobe, select, read/write and data lines.
// - Serial mode uses line five select, six clock, seven data.
// - Entry direction one increments the counter, zero decrements it.
// - Clear fills display RAM with spaces, zeroes counter, sets increment.
`timescale 1ns/10ps
`default_nettype none
`include "clp_defs.svh"
module clp_core
   import clp_pkg::*;
#(
   parameter int CLEAR_CYC = `CLP_CLEAR_CYC,
   parameter int BLINK_CYC = `CLP_BLINK_CYC
) (
   // Clock and reset.
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   // Interface straps.
   input  wire logic        IFACE_STRAP_HI,
   input  wire logic        IFACE_STRAP_LO,
   // Host bus pins.
   input  wire logic        E,
   input  wire logic        REGISTER_SELECT,
   input  wire logic        RW,
   input  wire logic [7:0]  DB_IN,
   output var  logic [7:0]  DB_OUT,
   output var  logic        DB_OE,
   // Display drive side.
   input  wire logic [6:0]  DISP_ADDR,
   output var  logic [7:0]  DISP_DATA,
   output var  logic        DISPLAY_ON,
   output var  logic        CURSOR_ON,
   output var  logic        BLINK_PHASE,
   output var  logic [6:0]  DISPLAY_SHIFT,
   output var  logic        LINE_TWO,
   output var  logic        FONT_5X11,
   output var  clp_duty_type DUTY_SEL,
   // Status.
   output var  logic        BUSY_FLAG,
   output var  logic [6:0]  ADDRESS_COUNTER,
   output var  logic        BUS_WIDTH_SEL,
   output var  clp_iface_type IFACE_MODE
);
   // Every assertion below watches this one clock and is off during reset.
   default clocking cb_sys @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   // Counter step with the address windows of each RAM and line mode.
   function automatic logic [6:0] clp_step(input logic [6:0] a,
      input logic up, input logic two, input logic cg);
      logic [6:0] r;
      r = a;
      if (cg) begin
         r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      end else if (!two) begin
         if (up) r = (a >= `CLP_DD_ONE_LAST) ? 7'h00 : a + 7'h01;
         else    r = (a == 7'h00) ? `CLP_DD_ONE_LAST : a - 7'h01;
      end else if (up) begin
         if (a == `CLP_DD_L1_LAST)      r = `CLP_DD_L2_FIRST;
         else if (a >= `CLP_DD_L2_LAST) r = 7'h00;
         else                           r = a + 7'h01;
      end else begin
         if (a == 7'h00)                 r = `CLP_DD_L2_LAST;
         else if (a == `CLP_DD_L2_FIRST) r = `CLP_DD_L1_LAST;
         else                            r = a - 7'h01;
      end
      return r;
   endfunction : clp_step

   // Display offset rotates over one line length; positive means left.
   function automatic logic [6:0] clp_rot(input logic [6:0] s,
      input logic left, input logic two);
      logic [6:0] last;
      last = two ? `CLP_DD_L1_LAST : `CLP_DD_ONE_LAST;
      if (left) return (s >= last) ? 7'h00 : s + 7'h01;
      return (s == 7'h00) ? last : s - 7'h01;
   endfunction : clp_rot

   clp_pins_type  pin;
   clp_cmd_type   spi_cmd;
   clp_iface_type iface_ff;
   clp_duty_type  duty_ff;
   logic [1:0]    strap_cnt_ff;
   logic          ready_ff;
   logic          bus_width_sel_ff;
   logic          line_two_ff;
   logic          font_ff;
   logic          disp_on_ff;
   logic          cursor_ff;
   logic          blink_en_ff;
   logic          entry_inc_ff;
   logic          entry_shift_ff;
   logic [6:0]    ac_ff;
   logic          cg_sel_ff;
   logic [6:0]    shift_ff;
   logic [7:0]    data_holding_reg_ff;
   logic          pend_ff;
   logic [`CLP_BUSY_W-1:0] busy_cnt_ff;
   logic          busy_ff;
   logic          clearing_ff;
   logic [6:0]    clr_idx_ff;
   logic          nib_ff;
   logic [3:0]    hi_nib_ff;
   logic          e_d_ff;
   logic [7:0]    db_out_ff;
   logic          db_oe_ff;
   logic [`CLP_BLINK_W-1:0] blink_cnt_ff;
   logic          blink_ph_ff;
   logic [7:0]    disp_data_ff;
   logic [7:0]    dd_mem_ff [`CLP_DD_DEPTH];
   logic [7:0]    cg_mem_ff [`CLP_CG_DEPTH];

   clp_sync #(.W($bits(clp_pins_type))) u_sync (
      .clk  (CLK_SYS),
      .nrst (NRST),
      .d    ({IFACE_STRAP_HI, IFACE_STRAP_LO, E, REGISTER_SELECT, RW, DB_IN}),
      .q    (pin)
   );

   wire par_on = ready_ff & (iface_ff == CLP_IF_PAR);
   wire spi_on = ready_ff & (iface_ff == CLP_IF_SPI);

   // Serial lines share the upper data pins.
   clp_spi_rx u_spi (
      .clk  (CLK_SYS),
      .nrst (NRST),
      .en   (spi_on),
      .cs_n (pin.db[`CLP_SPI_CSN]),
      .sck  (pin.db[`CLP_SPI_SCK]),
      .sdi  (pin.db[`CLP_SPI_SDI]),
      .rs   (pin.rs),
      .cmd  (spi_cmd)
   );

   clp_iface_type nxt_iface;
   assign nxt_iface = ({pin.strap_hi, pin.strap_lo} == 2'b10) ? CLP_IF_SPI :
                      ({pin.strap_hi, pin.strap_lo} == 2'b01) ? CLP_IF_TWI :
                      CLP_IF_PAR;

   // Parallel bus: transfer completes on the falling strobe edge.
   wire bus8    = bus_width_sel_ff;
   wire e_fall  = par_on & e_d_ff & ~pin.e;
   wire par_end = e_fall & (bus8 | nib_ff);
   wire par_wr  = par_end & ~pin.rw;
   wire rd_done = par_end & pin.rw & pin.rs & ~busy_ff;
   clp_cmd_type par_cmd;
   assign par_cmd = '{valid: par_wr, rs: pin.rs,
                      data: bus8 ? pin.db : {hi_nib_ff, pin.db[7:4]}};
   clp_cmd_type cmd;
   assign cmd = spi_cmd.valid ? spi_cmd : par_cmd;

   // Instructions arriving while busy are dropped.
   wire       go = cmd.valid & ~busy_ff;
   wire [7:0] b  = cmd.data;
   wire op_wr  = go & cmd.rs;
   wire op_dda = go & ~cmd.rs & b[7];
   wire op_cga = go & ~cmd.rs & (b[7:6] == 2'b01);
   wire op_fun = go & ~cmd.rs & (b[7:5] == 3'b001);
   wire op_shf = go & ~cmd.rs & (b[7:4] == 4'b0001);
   wire op_dsp = go & ~cmd.rs & (b[7:3] == 5'b00001);
   wire op_ent = go & ~cmd.rs & (b[7:2] == 6'b000001);
   wire op_hom = go & ~cmd.rs & (b[7:1] == 7'b0000001);
   wire op_clr = go & ~cmd.rs & (b == 8'h01);
   wire cur_mv = op_shf & ~b[`CLP_SHF_SC];
   wire dsp_mv = op_shf & b[`CLP_SHF_SC];
   wire ent_mv = op_wr & entry_shift_ff & ~cg_sel_ff;

   wire [6:0] nxt_ac =
      (op_clr | op_hom) ? `CLP_RST_AC :
      op_dda ? b[6:0] :
      op_cga ? {1'b0, b[5:0]} :
      cur_mv ? clp_step(ac_ff, b[`CLP_SHF_RL], line_two_ff, cg_sel_ff) :
      (op_wr | rd_done) ?
         clp_step(ac_ff, entry_inc_ff, line_two_ff, cg_sel_ff) :
      ac_ff;
   wire [6:0] nxt_shift =
      (op_clr | op_hom) ? 7'h00 :
      dsp_mv ? clp_rot(shift_ff, ~b[`CLP_SHF_RL], line_two_ff) :
      ent_mv ? clp_rot(shift_ff, entry_inc_ff, line_two_ff) :
      shift_ff;
   wire [`CLP_BUSY_W-1:0] nxt_busy_cnt =
      op_clr ? `CLP_BUSY_W'(CLEAR_CYC) :
      (go | rd_done) ? `CLP_BUSY_W'(`CLP_EXEC_CYC) :
      (busy_cnt_ff != '0) ? busy_cnt_ff - `CLP_BUSY_W'(1) : busy_cnt_ff;
   wire nxt_pend = op_dda | op_cga | cur_mv | rd_done;
   wire [7:0] ram_q = cg_sel_ff ? cg_mem_ff[ac_ff[5:0]] : dd_mem_ff[ac_ff];
   wire [7:0] rd_val = pin.rs ? data_holding_reg_ff : {busy_ff, ac_ff};
   wire [7:0] nxt_db_out = (bus8 | ~nib_ff) ? rd_val :
                           {rd_val[3:0], 4'h0};

   // Strap capture a few cycles after reset release.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         strap_cnt_ff <= 2'h0;
         ready_ff     <= 1'b0;
         iface_ff     <= CLP_IF_PAR;
      end else if (!ready_ff) begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         ready_ff     <= (strap_cnt_ff == 2'h3);
         iface_ff     <= nxt_iface;
      end
   end

   // Mode bits; reset values match the power-on initialisation.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         bus_width_sel_ff <= 1'b1;
         line_two_ff      <= 1'b0;
         font_ff          <= 1'b0;
         duty_ff          <= CLP_DUTY_8;
         disp_on_ff       <= 1'b0;
         cursor_ff        <= 1'b0;
         blink_en_ff      <= 1'b0;
         entry_inc_ff     <= 1'b1;
         entry_shift_ff   <= 1'b0;
      end else begin
         if (op_fun) begin
            bus_width_sel_ff <= b[`CLP_FUN_DL];
            line_two_ff      <= b[`CLP_FUN_N];
            font_ff          <= b[`CLP_FUN_F];
            duty_ff <= b[`CLP_FUN_N] ? CLP_DUTY_16 :
                       b[`CLP_FUN_F] ? CLP_DUTY_11 : CLP_DUTY_8;
         end
         if (op_dsp) begin
            disp_on_ff  <= b[`CLP_DSP_D];
            cursor_ff   <= b[`CLP_DSP_C];
            blink_en_ff <= b[`CLP_DSP_B];
         end
         if (op_ent) begin
            entry_inc_ff   <= b[`CLP_ENT_ID];
            entry_shift_ff <= b[`CLP_ENT_S];
         end else if (op_clr) begin
            entry_inc_ff <= 1'b1;
         end
      end
   end

   // Counter, RAM select, read preload and busy timing.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         ac_ff               <= `CLP_RST_AC;
         cg_sel_ff           <= 1'b0;
         shift_ff            <= 7'h00;
         pend_ff             <= 1'b0;
         data_holding_reg_ff <= `CLP_SPACE_CODE;
         busy_cnt_ff         <= `CLP_BUSY_W'(CLEAR_CYC);
         busy_ff             <= 1'b1;
         clearing_ff         <= 1'b1;
         clr_idx_ff          <= 7'h00;
      end else begin
         ac_ff       <= nxt_ac;
         shift_ff    <= nxt_shift;
         pend_ff     <= nxt_pend;
         busy_cnt_ff <= nxt_busy_cnt;
         busy_ff     <= (nxt_busy_cnt != '0) | op_clr | clearing_ff;
         if (op_cga) cg_sel_ff <= 1'b1;
         else if (op_dda | op_clr | op_hom) cg_sel_ff <= 1'b0;
         if (pend_ff) data_holding_reg_ff <= ram_q;
         if (op_clr) begin
            clearing_ff <= 1'b1;
            clr_idx_ff  <= 7'h00;
         end else if (clearing_ff) begin
            clr_idx_ff  <= clr_idx_ff + 7'h01;
            clearing_ff <= (clr_idx_ff != 7'h7f);
         end
      end
   end

   // RAM cells; writes ignore the display enable so blanking loses nothing.
   for (genvar i = 0; i < `CLP_DD_DEPTH; i++) begin : g_dd
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            dd_mem_ff[i] <= `CLP_SPACE_CODE;
         end else if (clearing_ff && clr_idx_ff == 7'(i)) begin
            dd_mem_ff[i] <= `CLP_SPACE_CODE;
         end else if (op_wr && !cg_sel_ff && ac_ff == 7'(i)) begin
            dd_mem_ff[i] <= b;
         end
      end
   end
   for (genvar i = 0; i < `CLP_CG_DEPTH; i++) begin : g_cg
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            cg_mem_ff[i] <= `CLP_RST_CG_DATA;
         end else if (op_wr && cg_sel_ff && ac_ff[5:0] == 6'(i)) begin
            cg_mem_ff[i] <= b;
         end
      end
   end

   // Parallel bus nibble pairing and read drive.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         e_d_ff    <= 1'b0;
         nib_ff    <= 1'b0;
         hi_nib_ff <= 4'h0;
         db_out_ff <= 8'h00;
         db_oe_ff  <= 1'b0;
      end else begin
         e_d_ff   <= pin.e;
         db_oe_ff <= par_on & pin.e & pin.rw;
         if (par_on & pin.e & pin.rw) db_out_ff <= nxt_db_out;
         if (e_fall & ~bus8) begin
            nib_ff    <= ~nib_ff;
            hi_nib_ff <= pin.db[7:4];
         end else if (bus8) begin
            nib_ff <= 1'b0;
         end
      end
   end

   // Blink phase and display read port.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         blink_cnt_ff <= '0;
         blink_ph_ff  <= 1'b0;
         disp_data_ff <= `CLP_SPACE_CODE;
      end else begin
         disp_data_ff <= dd_mem_ff[DISP_ADDR];
         if (!blink_en_ff) begin
            blink_cnt_ff <= '0;
            blink_ph_ff  <= 1'b0;
         end else if (blink_cnt_ff == `CLP_BLINK_W'(BLINK_CYC - 1)) begin
            blink_cnt_ff <= '0;
            blink_ph_ff  <= ~blink_ph_ff;
         end else begin
            blink_cnt_ff <= blink_cnt_ff + `CLP_BLINK_W'(1);
         end
      end
   end

   assign DB_OUT          = db_out_ff;
   assign DB_OE           = db_oe_ff;
   assign DISP_DATA       = disp_data_ff;
   assign DISPLAY_ON      = disp_on_ff;
   assign CURSOR_ON       = cursor_ff;
   assign BLINK_PHASE     = blink_ph_ff;
   assign DISPLAY_SHIFT   = shift_ff;
   assign LINE_TWO        = line_two_ff;
   assign FONT_5X11       = font_ff;
   assign DUTY_SEL        = duty_ff;
   assign BUSY_FLAG       = busy_ff;
   assign ADDRESS_COUNTER = ac_ff;
   assign BUS_WIDTH_SEL   = bus_width_sel_ff;
   assign IFACE_MODE      = iface_ff;

   a_write_busy: assert property (op_wr |=> busy_ff ##1 busy_ff)
      else $error("busy flag not raised after data write");
   a_cg_step: assert property (op_wr && cg_sel_ff && entry_inc_ff
      |=> ac_ff[5:0] == $past(ac_ff[5:0]) + 6'h01)
      else $error("counter did not step after character write");
   a_dshift_ac: assert property (dsp_mv |=>
      $stable(ac_ff) && shift_ff != $past(shift_ff))
      else $error("display shift disturbed the counter");
   a_line_wrap: assert property (cur_mv && b[`CLP_SHF_RL] &&
      line_two_ff && !cg_sel_ff && ac_ff == `CLP_DD_L1_LAST
      |=> ac_ff == `CLP_DD_L2_FIRST)
      else $error("cursor did not move to the second line");
   a_dd_set: assert property (op_dda |=>
      ac_ff == $past(b[6:0]) && !cg_sel_ff ##1 pend_ff == 1'b0)
      else $error("display address set not taken");
   a_clear_home: assert property (op_clr |=>
      ac_ff == 7'h00 && entry_inc_ff && busy_ff [*8])
      else $error("clear did not home the counter");
   a_status_rd: assert property (par_on && bus8 && pin.e &&
      pin.rw && !pin.rs |=> DB_OE && DB_OUT == $past({busy_ff, ac_ff}))
      else $error("status read returned wrong value");
   a_nib_busy: assert property (e_fall && !bus8 && !nib_ff |=>
      !$rose(busy_ff))
      else $error("busy raised after the first nibble");
   a_blink_off: assert property (!blink_en_ff |=> !blink_ph_ff)
      else $error("blink phase toggling while blink is off");
endmodule : clp_core
`default_nettype wire

// *** test/clp_host.sv ***
/*
 Host model on the parallel bus: strobes, busy polling, reads, nibble mode;
 and a four-line serial master on the upper data pins.
 Assumes the core answers a read within six clocks of the strobe rising.
*/
`timescale 1ns/10ps
`default_nettype none
module clp_host (
   // Clock.
   input  wire logic       clk,
   // Bus.
   input  wire logic [7:0] db_out,
   output var  logic       e = 1'b0,
   output var  logic       rs = 1'b0,
   output var  logic       rw = 1'b0,
   output var  logic [7:0] db = 8'h00,
   // Read results.
   output var  logic       rd_done = 1'b0,
   output var  logic [7:0] rd_data = 8'h00
);
   logic nib = 1'b0;
   task strobe(input logic s, input logic w, input logic [7:0] d,
               output logic [7:0] q);
      @(negedge clk);
      rs = s;
      rw = w;
      db = d;
      e  = 1'b1;
      repeat (6) @(negedge clk);
      q = db_out;
      e = 1'b0;
      repeat (6) @(negedge clk);
      // Released lines must not keep looking valid.
      db = ~d;
   endtask : strobe
   task xfer(input logic s, input logic w, input logic [7:0] d,
             output logic [7:0] q);
      logic [7:0] h;
      logic [7:0] l;
      if (nib) begin
         strobe(s, w, {d[7:4], 4'h0}, h);
         strobe(s, w, {d[3:0], 4'h0}, l);
         q = {h[7:4], l[7:4]};
      end else begin
         strobe(s, w, d, q);
      end
   endtask : xfer
   task poll;
      logic [7:0] q;
      q = 8'h80;
      for (int i = 0; i < 400 && q[7]; i++) xfer(1'b0, 1'b1, 8'h00, q);
      @(negedge clk);
   endtask : poll
   task wr(input logic s, input logic [7:0] d);
      logic [7:0] q;
      poll();
      xfer(s, 1'b0, d, q);
   endtask : wr
   task rd(input logic s);
      logic [7:0] q;
      poll();
      xfer(s, 1'b1, 8'h00, q);
      rd_data = q;
      rd_done = 1'b1;
      @(negedge clk);
      rd_done = 1'b0;
   endtask : rd
   // Serial clock idles high and only runs inside a frame, 80 ns a period.
   task spi(input logic s, input logic [7:0] d);
      @(negedge clk);
      rs = s;
      db = 8'hdf;
      for (int i = 7; i >= 0; i--) begin
         repeat (4) @(negedge clk);
         db[6] = 1'b0;
         db[7] = d[i];
         repeat (4) @(negedge clk);
         db[6] = 1'b1;
      end
      repeat (4) @(negedge clk);
      db = 8'hff;
   endtask : spi
endmodule : clp_host
`default_nettype wire

// *** test/clp_core_bench.sv ***
/*
 Self-checking bench of the instruction port on the parallel bus, then on
 the four-line serial link after a closing reset with the straps changed.
 Assumes a short clear time and a short blink period.
*/
`timescale 1ns/10ps
`default_nettype none
module clp_core_bench import clp_pkg::*; ;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
   logic CLK_SYS = 1'b0;
   logic NRST = 1'b0;
   logic [6:0] disp_addr = 7'h10;
   logic strap_hi = 1'b0;
   logic ph;
   wire logic e, rs, rw, rd_done, disp_on, curs_on, line_two, busy, width;
   wire logic font, blink;
   wire logic [7:0] db, db_out, disp_data, rd_data;
   wire logic [6:0] shift, ac;
   wire clp_duty_type duty;
   wire clp_iface_type iface;
   int checks = 0;
   int miscompares = 0;
   logic [7:0] notes[$];
   logic [7:0] b1, b2, note;
   always #5 CLK_SYS = ~CLK_SYS;
   clp_core #(.CLEAR_CYC(200), .BLINK_CYC(20)) clp_core_inst (
      .CLK_SYS(CLK_SYS), .NRST(NRST), .IFACE_STRAP_HI(strap_hi),
      .IFACE_STRAP_LO(1'b0), .E(e), .REGISTER_SELECT(rs), .RW(rw),
      .DB_IN(db), .DB_OUT(db_out), .DB_OE(), .DISP_ADDR(disp_addr),
      .DISP_DATA(disp_data), .DISPLAY_ON(disp_on), .CURSOR_ON(curs_on),
      .BLINK_PHASE(blink), .DISPLAY_SHIFT(shift), .LINE_TWO(line_two),
      .FONT_5X11(font), .DUTY_SEL(duty), .BUSY_FLAG(busy),
      .ADDRESS_COUNTER(ac), .BUS_WIDTH_SEL(width), .IFACE_MODE(iface));
   clp_host clp_host_inst (.clk(CLK_SYS), .db_out(db_out), .e(e), .rs(rs),
      .rw(rw), .db(db), .rd_done(rd_done), .rd_data(rd_data));
   task finish_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task rdx(input logic s, input logic [7:0] exp);
      notes.push_back(exp);
      clp_host_inst.rd(s);
   endtask : rdx
   // Read results are taken on a clock edge, where both host lines settled.
   always @(posedge CLK_SYS) begin
      if (rd_done) begin
         note = notes.pop_front();
         `CHK(rd_data, note)
      end
   end
   initial begin
      #900000;
      miscompares++;
      finish_test();
   end
   initial begin
      void'($urandom(27406));
      b1 = $urandom;
      b2 = $urandom;
      repeat (4) @(posedge CLK_SYS);
      @(negedge CLK_SYS) NRST = 1'b1;
      rdx(1'b0, 8'h00);
      `CHK(disp_data, 8'h20)
      for (int i = 0; i < 3; i++) begin
         clp_host_inst.wr(1'b0, 8'h30 | 8'(i << 2));
         `CHK(duty, 2'(i))
         `CHK(line_two, 1'(i == 2))
         `CHK(font, 1'(i == 1))
      end
      `CHK(busy, 1'b1)
      clp_host_inst.wr(1'b0, 8'h0c);
      `CHK({disp_on, curs_on}, 2'b10)
      clp_host_inst.wr(1'b0, 8'h0d);
      ph = blink;
      repeat (20) @(negedge CLK_SYS);
      `CHK(blink, ~ph)
      clp_host_inst.wr(1'b0, 8'h0c);
      `CHK(blink, 1'b0)
      clp_host_inst.wr(1'b0, 8'ha7);
      clp_host_inst.wr(1'b1, b1);
      rdx(1'b0, 8'h40);
      `CHK(ac, 7'h40)
      clp_host_inst.wr(1'b0, 8'ha7);
      rdx(1'b1, b1);
      rdx(1'b0, 8'h40);
      clp_host_inst.wr(1'b0, 8'h18);
      `CHK(shift, 7'h01)
      rdx(1'b0, 8'h40);
      clp_host_inst.wr(1'b0, 8'h10);
      rdx(1'b0, 8'h27);
      clp_host_inst.wr(1'b0, 8'h08);
      clp_host_inst.wr(1'b0, 8'h45);
      clp_host_inst.wr(1'b1, b2);
      clp_host_inst.wr(1'b0, 8'h45);
      rdx(1'b1, b2);
      `CHK(disp_on, 1'b0)
      disp_addr = 7'h27;
      repeat (2) @(negedge CLK_SYS);
      `CHK(disp_data, b1)
      clp_host_inst.wr(1'b0, 8'h04);
      clp_host_inst.wr(1'b0, 8'h85);
      clp_host_inst.wr(1'b1, b2);
      rdx(1'b0, 8'h04);
      clp_host_inst.wr(1'b0, 8'h01);
      rdx(1'b0, 8'h00);
      `CHK({shift, disp_data}, {7'h00, 8'h20})
      clp_host_inst.wr(1'b1, b1);
      rdx(1'b0, 8'h01);
      clp_host_inst.wr(1'b0, 8'h28);
      `CHK(width, 1'b0)
      clp_host_inst.nib = 1'b1;
      clp_host_inst.wr(1'b0, 8'h83);
      rdx(1'b0, 8'h03);
      @(negedge CLK_SYS) NRST = 1'b0;
      strap_hi = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      NRST = 1'b1;
      repeat (210) @(negedge CLK_SYS);
      `CHK(busy, 1'b0)
      clp_host_inst.spi(1'b0, 8'h38);
      repeat (10) @(negedge CLK_SYS);
      `CHK({iface, line_two, busy}, {CLP_IF_SPI, 2'b11})
      finish_test();
   end
endmodule : clp_core_bench
`default_nettype wire
